/* File: core/dcs_defs.svh */
`ifndef DCS_DEFS_SVH
`define DCS_DEFS_SVH
// register offsets in the memory window
`define DCS_OFF_DOTCLK      8'h24
`define DCS_OFF_SIG         8'h28
// reset values
`define DCS_DOTCLK_RESET    32'h00000000
`define DCS_SIG_RESET       32'h00000100
// writable bits; reserved bits read back as zero, read-only signature bits read back the signature
`define DCS_DOTCLK_WMASK    32'hdffffd07
`define DCS_SIG_WMASK       32'h000000ef
// field positions in the dot clock register
`define DCS_BIT_BYPASS      8
`define DCS_BIT_CLKON       11
`define DCS_BIT_PLUS1       23
`define DCS_FB_LSB          12
`define DCS_FB_MSB          22
// signature generator
`define DCS_SIG_SEED        24'h000001
`define DCS_SIG_POLY        24'h864cfb
// feedback code walk: code of count 1, largest count
`define DCS_FB_FIRST_CODE   11'h3ff
`define DCS_FB_MAX_COUNT    9'h190
// post divisor codes with special meaning
`define DCS_PD_ONE_CODE     5'h0f
`define DCS_PD_RESERVED     5'h1f
// lowest legal oscillator frequency, MHz (software keeps to it)
`define DCS_VCO_MIN_MHZ     140
`endif

/* File: core/dcs_dot_clock_sig.sv */
`timescale 1ns/1ps
`include "dcs_defs.svh"
// Functional notes
// (RULE1) bypass set sends the reference straight to the dot clock output
// (RULE2) bypass set drives the oscillator control to its power-down level
// (RULE3) input divisor is the three-bit field plus two, 2 to 9
// (RULE4) software keeps the oscillator frequency above 140 MHz
// (RULE5) feedback divisor is twice the decoded count plus the adjust bit
// (RULE6) eleven-bit feedback code maps to counts 1 to 400 by a fixed walk
// (RULE7) upper 24 bits of the signature register are read-only signature
// (RULE8) sync override drives CRT syncs onto the panel sync pins
// (RULE9) panel clock invert bit inverts the panel clock output
// (RULE10) even clock invert bit inverts the even-pixel panel clock
// (RULE11) source bit picks RGB or panel data, panel in top six bits
// (RULE12) free-run captures every frame; clearing it stops at frame end
// (RULE13) override plus delay bit delays panel hsync by two more cycles
// (RULE14) software keeps the delay bit clear while override is clear
// (RULE15) signature enable low resets signature to 000001h and holds it
// (RULE16) enable high starts capture at next vsync, one update per pixel
// (RULE17) dot clock bit 5 is read-only reserved; writes are ignored
// (RULE18) five-bit post code selects divide 1 to 31, all-ones reserved
// (RULE19) run bit enables the synthesiser; post divide one forces it on
// (RULE20) dot clock rate is reference times feedback over input by post
// (RULE21) signature uses one fixed 24-bit compression step per pixel
module dcs_dot_clock_sig
  import dcs_pkg::*;
#(
  parameter int ACC_W = 16
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  output      logic [31:0] regRdData,
  input  wire dcs_pins_t   pinsIn,
  output      logic        dotClock,
  output      logic        vcoPowerDown,
  output      logic        pllEnabled,
  output      logic [3:0]  pllInputDivisor,
  output      logic [9:0]  feedbackDivisor,
  output      logic [4:0]  postDivisor,
  output      logic        feedbackValid,
  output      logic        panelVerticalSyncPin,
  output      logic        panelHorizontalSyncPin,
  output      logic        panelClock,
  output      logic        panelEvenClock
);

  if (ACC_W < 12 || ACC_W > 24) begin : g_chk
    $error("ACC_W must lie between 12 and 24");
  end

  // one step of the feedback code walk, code(n-1) = step(code(n))
  function automatic logic [10:0] fbStep(input logic [10:0] c);
    fbStep = {c[9:0], ~(c[10] ^ c[8])};
  endfunction

  // post divisor encoding; reserved code yields zero
  function automatic logic [4:0] pdDecode(input logic [4:0] c);
    case (c)
      5'h00: pdDecode = 5'h08;  5'h01: pdDecode = 5'h06;
      5'h02: pdDecode = 5'h12;  5'h03: pdDecode = 5'h04;
      5'h04: pdDecode = 5'h0c;  5'h05: pdDecode = 5'h10;
      5'h06: pdDecode = 5'h18;  5'h07: pdDecode = 5'h02;
      5'h08: pdDecode = 5'h0a;  5'h09: pdDecode = 5'h14;
      5'h0a: pdDecode = 5'h0e;  5'h0b: pdDecode = 5'h1a;
      5'h0c: pdDecode = 5'h16;  5'h0d: pdDecode = 5'h1c;
      5'h0e: pdDecode = 5'h1e;  5'h0f: pdDecode = 5'h01;
      5'h10: pdDecode = 5'h09;  5'h11: pdDecode = 5'h07;
      5'h12: pdDecode = 5'h13;  5'h13: pdDecode = 5'h05;
      5'h14: pdDecode = 5'h0d;  5'h15: pdDecode = 5'h11;
      5'h16: pdDecode = 5'h19;  5'h17: pdDecode = 5'h03;
      5'h18: pdDecode = 5'h0b;  5'h19: pdDecode = 5'h15;
      5'h1a: pdDecode = 5'h0f;  5'h1b: pdDecode = 5'h1b;
      5'h1c: pdDecode = 5'h17;  5'h1d: pdDecode = 5'h1d;
      5'h1e: pdDecode = 5'h1f;
      default: pdDecode = 5'h00;
    endcase
  endfunction

  // ---------------- pin synchronisers ----------------
  dcs_pins_t pinS1, pinS2, pinPrev;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinS1   <= '0;
      pinS2   <= '0;
      pinPrev <= '0;
    end else begin
      pinS1   <= pinsIn;
      pinS2   <= pinS1;
      pinPrev <= pinS2;
    end
  end

  logic refEdge, pixEdge, vsEdge;
  assign refEdge = pinS2.refClock & ~pinPrev.refClock;
  assign pixEdge = pinS2.pixelClock & ~pinPrev.pixelClock;
  assign vsEdge  = pinS2.crtVsync & ~pinPrev.crtVsync;

  // ---------------- registers ----------------
  dcs_dotcfg_t dotCfg, next_dotCfg;
  dcs_sigcfg_t sigCfg, next_sigCfg;
  logic [23:0] sigValue, next_sigValue;
  logic [31:0] next_regRdData;
  logic        wrDot, wrSig;

  assign wrDot = regWrite && regAddr == `DCS_OFF_DOTCLK;
  assign wrSig = regWrite && regAddr == `DCS_OFF_SIG;

  // masked writes keep reserved bits at zero
  always_comb begin
    next_dotCfg = dotCfg;
    next_sigCfg = sigCfg;
    next_regRdData = 32'h00000000;
    if (wrDot) begin
      next_dotCfg = (regWrData & `DCS_DOTCLK_WMASK); // see (RULE17)
    end else if (wrSig) begin
      next_sigCfg = (regWrData & `DCS_SIG_WMASK); // see (RULE7)
    end
    if (regRead && regAddr == `DCS_OFF_DOTCLK) begin
      next_regRdData = dotCfg;
    end else if (regRead && regAddr == `DCS_OFF_SIG) begin
      next_regRdData = {sigValue, sigCfg[7:0]}; // see (RULE7)
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dotCfg    <= `DCS_DOTCLK_RESET;
      sigCfg    <= `DCS_SIG_RESET & `DCS_SIG_WMASK;
      regRdData <= 32'h00000000;
    end else begin
      dotCfg    <= next_dotCfg;
      sigCfg    <= next_sigCfg;
      regRdData <= next_regRdData;
    end
  end

  // ---------------- feedback code decoder ----------------
  // walks the code towards the count-1 code; one step a cycle saves a
  // 400-entry table at the price of up to 400 cycles after each write
  dcs_fbstate_t fbState, next_fbState;
  logic [10:0]  fbWalk, next_fbWalk;
  logic [8:0]   fbCount, next_fbCount;

  always_comb begin
    next_fbState = fbState;
    next_fbWalk  = fbWalk;
    next_fbCount = fbCount;
    case (fbState)
      FB_IDLE, FB_DONE: begin
        if (wrDot) begin
          next_fbState = FB_SEARCH;
          next_fbWalk  = regWrData[`DCS_FB_MSB:`DCS_FB_LSB];
          next_fbCount = 9'h001;
        end
      end
      default: begin
        if (wrDot) begin
          next_fbWalk  = regWrData[`DCS_FB_MSB:`DCS_FB_LSB];
          next_fbCount = 9'h001;
        end else if (fbWalk == `DCS_FB_FIRST_CODE) begin
          next_fbState = FB_DONE; // see (RULE6)
        end else if (fbCount == `DCS_FB_MAX_COUNT) begin
          next_fbState = FB_IDLE; // code outside the table
        end else begin
          next_fbWalk  = fbStep(fbWalk); // see (RULE6)
          next_fbCount = fbCount + 9'h001;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fbState <= FB_IDLE;
      fbWalk  <= 11'h000;
      fbCount <= 9'h000;
    end else begin
      fbState <= next_fbState;
      fbWalk  <= next_fbWalk;
      fbCount <= next_fbCount;
    end
  end

  // ---------------- dot clock synthesis ----------------
  // fractional accumulator: each reference edge adds the feedback divisor,
  // each tick removes input times post divisor; one tick per mclk at most,
  // so ratios that would exceed mclk saturate the accumulator
  logic [ACC_W-1:0] acc, next_acc, accAdd, limit;
  logic [8:0]  limit9;
  logic        running, runOk, next_dotClock;
  logic [3:0]  next_inDiv;
  logic [9:0]  next_fbDiv;
  logic [4:0]  next_pdDiv;

  always_comb begin
    next_inDiv = {1'b0, dotCfg.inCode} + 4'h2; // see (RULE3)
    next_fbDiv = {fbCount, 1'b0} + {9'h000, dotCfg.plus1}; // see (RULE5)
    next_pdDiv = pdDecode(dotCfg.postCode); // see (RULE18)
    running = dotCfg.clkOn ||
              dotCfg.postCode == `DCS_PD_ONE_CODE; // see (RULE19)
    runOk = running && !dotCfg.pllReset && fbState == FB_DONE &&
            feedbackValid && postDivisor != 5'h00 && !dotCfg.bypass;
    limit9 = {5'h00, pllInputDivisor} * {4'h0, postDivisor};
    limit  = ACC_W'(limit9);
    accAdd = acc;
    if (refEdge && !acc[ACC_W-1]) begin
      accAdd = acc + ACC_W'(feedbackDivisor);
    end
    next_acc = '0;
    next_dotClock = 1'b0;
    if (dotCfg.bypass) begin
      next_dotClock = refEdge; // see (RULE1)
    end else if (runOk) begin
      if (accAdd >= limit) begin
        next_dotClock = 1'b1; // see (RULE20)
        next_acc = accAdd - limit;
      end else begin
        next_acc = accAdd;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc             <= '0;
      dotClock        <= 1'b0;
      vcoPowerDown    <= 1'b0;
      pllEnabled      <= 1'b0;
      pllInputDivisor <= 4'h2;
      feedbackDivisor <= 10'h000;
      postDivisor     <= 5'h00;
      feedbackValid   <= 1'b0;
    end else begin
      acc             <= next_acc;
      dotClock        <= next_dotClock;
      vcoPowerDown    <= dotCfg.bypass; // see (RULE2)
      pllEnabled      <= running;
      pllInputDivisor <= next_inDiv;
      feedbackDivisor <= next_fbDiv;
      postDivisor     <= next_pdDiv;
      feedbackValid   <= fbState == FB_DONE && !wrDot;
    end
  end

  // ---------------- panel sync and clock pins ----------------
  logic [1:0] hsDelay;
  logic       next_pV, next_pH;

  always_comb begin
    next_pV = pinS2.panelVsyncIn;
    next_pH = pinS2.panelHsyncIn;
    if (sigCfg.syncOverride) begin
      next_pV = pinS2.crtVsync; // see (RULE8)
      next_pH = sigCfg.hsyncDelay ? hsDelay[1] // see (RULE13)
                                  : pinS2.crtHsync;
    end
  end

  // clocks pass through the synchroniser, so they lag by mclk cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hsDelay                <= 2'b00;
      panelVerticalSyncPin   <= 1'b0;
      panelHorizontalSyncPin <= 1'b0;
      panelClock             <= 1'b0;
      panelEvenClock         <= 1'b0;
    end else begin
      hsDelay                <= {hsDelay[0], pinS2.crtHsync};
      panelVerticalSyncPin   <= next_pV;
      panelHorizontalSyncPin <= next_pH;
      panelClock     <= pinS2.panelClockIn ^ sigCfg.invPanelClock; // see (RULE9)
      panelEvenClock <= pinS2.panelEvenIn ^ sigCfg.invEvenClock; // see (RULE10)
    end
  end

  // ---------------- video signature ----------------
  dcs_sigstate_t sigState, next_sigState;
  logic [23:0]   pixWord;

  always_comb begin
    pixWord = pinS2.rgbData;
    if (sigCfg.srcPanel) begin
      pixWord = {pinS2.panelData[17:12], 2'b00, // see (RULE11)
                 pinS2.panelData[11:6], 2'b00,
                 pinS2.panelData[5:0], 2'b00};
    end
    next_sigState = sigState;
    next_sigValue = sigValue;
    case (sigState)
      SIG_OFF: begin
        next_sigValue = `DCS_SIG_SEED;
        if (sigCfg.sigEnable) next_sigState = SIG_ARM;
      end
      SIG_ARM: begin
        if (vsEdge) next_sigState = SIG_RUN; // see (RULE16)
      end
      SIG_RUN: begin
        if (vsEdge && !sigCfg.freeRun) begin
          next_sigState = SIG_HOLD; // see (RULE12)
        end else if (pixEdge) begin
          next_sigValue = {sigValue[22:0], 1'b0} ^ pixWord ^ // see (RULE21)
                          (sigValue[23] ? `DCS_SIG_POLY : 24'h000000);
        end
      end
      default: ;
    endcase
    if (!sigCfg.sigEnable) begin
      next_sigState = SIG_OFF;
      next_sigValue = `DCS_SIG_SEED; // see (RULE15)
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sigState <= SIG_OFF;
      sigValue <= `DCS_SIG_SEED;
    end else begin
      sigState <= next_sigState;
      sigValue <= next_sigValue;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_fbWrite400;
    wrDot && regWrData[`DCS_FB_MSB:`DCS_FB_LSB] == 11'h33a;
  endsequence
  sequence s_fbFound400;
    fbState == FB_DONE && fbCount == 9'h190;
  endsequence

  a_bypass_tick: assert property (dotCfg.bypass && refEdge |=> dotClock)
    else $error("bypass edge not passed"); // see (RULE1)
  a_vco_down: assert property (dotCfg.bypass |=> vcoPowerDown)
    else $error("vco not powered down"); // see (RULE2)
  a_input_div: assert property (##1 pllInputDivisor ==
                                $past(dotCfg.inCode) + 4'h2)
    else $error("input divisor wrong"); // see (RULE3)
  a_fb_pair: assert property (fbState == FB_DONE ##1 feedbackValid |->
      feedbackDivisor == {$past(fbCount), $past(dotCfg.plus1)})
    else $error("feedback divisor wrong"); // see (RULE5)
  a_fb_lookup: assert property (s_fbWrite400 ##1 !wrDot[*2] |->
                                ##[1:400] s_fbFound400)
    else $error("code 33a not decoded"); // see (RULE6)
  // a write that drops enable reseeds on purpose, so it is left out here
  a_sig_readonly: assert property (wrSig && regWrData[0] &&
      sigCfg.sigEnable && sigState != SIG_RUN |=> $stable(sigValue))
    else $error("write altered signature"); // see (RULE7)
  a_sync_override: assert property (sigCfg.syncOverride |=>
      panelVerticalSyncPin == $past(pinS2.crtVsync))
    else $error("vsync override wrong"); // see (RULE8)
  a_clk_invert: assert property (##1 panelClock ==
      ($past(pinS2.panelClockIn) ^ $past(sigCfg.invPanelClock)))
    else $error("panel clock polarity wrong"); // see (RULE9)
  a_hsync_delay: assert property (sigCfg.syncOverride &&
      sigCfg.hsyncDelay |=> panelHorizontalSyncPin ==
      $past(pinS2.crtHsync, 3))
    else $error("hsync delay wrong"); // see (RULE13)
  a_free_stop: assert property (sigState == SIG_RUN && vsEdge &&
      !sigCfg.freeRun && sigCfg.sigEnable |=> sigState == SIG_HOLD)
    else $error("capture did not stop"); // see (RULE12)
  a_sig_seed: assert property (!sigCfg.sigEnable |=>
                               sigValue == 24'h000001)
    else $error("signature not seeded"); // see (RULE15)
  a_arm_start: assert property (sigState == SIG_ARM && vsEdge &&
      sigCfg.sigEnable |=> sigState == SIG_RUN)
    else $error("capture did not start"); // see (RULE16)

endmodule

/* File: core/dcs_pkg.sv */
package dcs_pkg;
  // dot clock synthesiser configuration word
  typedef struct packed {
    logic        pllReset;
    logic        halfClockOff;
    logic        res29;
    logic [4:0]  postCode;
    logic        plus1;
    logic [10:0] fbCode;
    logic        clkOn;
    logic        dotSelect;
    logic        res9;
    logic        bypass;
    logic [1:0]  res7;
    logic        res5;
    logic [1:0]  res4;
    logic [2:0]  inCode;
  } dcs_dotcfg_t;

  // signature and panel configuration word
  typedef struct packed {
    logic [23:0] signature;
    logic        syncOverride;
    logic        invPanelClock;
    logic        invEvenClock;
    logic        res4;
    logic        srcPanel;
    logic        freeRun;
    logic        hsyncDelay;
    logic        sigEnable;
  } dcs_sigcfg_t;

  // pin inputs, all from outside the mclk domain
  typedef struct packed {
    logic        refClock;
    logic        pixelClock;
    logic        crtVsync;
    logic        crtHsync;
    logic        panelVsyncIn;
    logic        panelHsyncIn;
    logic        panelClockIn;
    logic        panelEvenIn;
    logic [23:0] rgbData;
    logic [17:0] panelData;
  } dcs_pins_t;

  typedef enum logic [1:0] {
    FB_IDLE   = 2'b00,
    FB_SEARCH = 2'b01,
    FB_DONE   = 2'b11
  } dcs_fbstate_t;

  typedef enum logic [1:0] {
    SIG_OFF  = 2'b00,
    SIG_ARM  = 2'b01,
    SIG_RUN  = 2'b11,
    SIG_HOLD = 2'b10
  } dcs_sigstate_t;
endpackage

/* File: tb/dcs_pipe_model.sv */
`timescale 1ns/1ps
module dcs_pipe_model
  import dcs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [3:0] lvl,
  output      dcs_pins_t  pins
);
  // reference oscillator runs free, ten mclk per period
  initial begin
    pins = '0;
    forever begin
      repeat (5) @(negedge mclk);
      pins.refClock = ~pins.refClock;
    end
  end

  // panel-side levels are static, chosen by the bench
  always @(negedge mclk) begin
    {pins.panelVsyncIn, pins.panelHsyncIn} = lvl[3:2];
    {pins.panelClockIn, pins.panelEvenIn} = lvl[1:0];
  end

  // one frame: vsync, n pixels with hsync every fourth, closing vsync
  task automatic frame(input int n);
    pins.crtVsync = 1'b1;
    repeat (6) @(negedge mclk);
    pins.crtVsync = 1'b0;
    for (int i = 0; i < n; i++) begin
      pins.rgbData = 24'h5a3c00 + 24'(i);
      pins.panelData = 18'h2a5c0 ^ 18'(i);
      pins.crtHsync = (i % 4 == 0);
      repeat (2) @(negedge mclk);
      pins.pixelClock = 1'b1;
      repeat (2) @(negedge mclk);
      pins.pixelClock = 1'b0;
    end
    pins.crtHsync = 1'b0;
    pins.crtVsync = 1'b1;
    // released data lines must not look like held pixels
    pins.rgbData = ~pins.rgbData;
    pins.panelData = ~pins.panelData;
    repeat (6) @(negedge mclk);
    pins.crtVsync = 1'b0;
    repeat (6) @(negedge mclk);
  endtask
endmodule

/* File: tb/dot_clock_pll_and_video_signature_test.sv */
`timescale 1ns/1ps
`include "dcs_defs.svh"
module dot_clock_pll_and_video_signature_test;
  import dcs_pkg::*;
  logic        mclk, rst, regWrite, regRead;
  logic [7:0]  regAddr;
  logic [31:0] regWrData, regRdData;
  logic [3:0]  lvl, pllInputDivisor;
  logic [9:0]  feedbackDivisor;
  logic [4:0]  postDivisor;
  logic        dotClock, vcoPowerDown, pllEnabled, feedbackValid;
  logic        panelVerticalSyncPin, panelHorizontalSyncPin;
  logic        panelClock, panelEvenClock;
  dcs_pins_t   pins;
  int          failCount = 0;
  int          checkCount = 0;

  dcs_dot_clock_sig uut (
    .mclk(mclk), .rst(rst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .pinsIn(pins), .dotClock(dotClock), .vcoPowerDown(vcoPowerDown),
    .pllEnabled(pllEnabled), .pllInputDivisor(pllInputDivisor),
    .feedbackDivisor(feedbackDivisor), .postDivisor(postDivisor),
    .feedbackValid(feedbackValid),
    .panelVerticalSyncPin(panelVerticalSyncPin),
    .panelHorizontalSyncPin(panelHorizontalSyncPin),
    .panelClock(panelClock), .panelEvenClock(panelEvenClock));

  dcs_pipe_model pm (.mclk(mclk), .lvl(lvl), .pins(pins));

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic results;
    $display("checks %0d, mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      failCount++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // a used-up wait bound ends the run
  task automatic guard(input int k, input int lim);
    if (k >= lim) begin
      failCount++;
      $display("unexpected wait: expected done, seen timeout");
      results();
    end
  endtask

  // strobes change at the falling edge, one cycle wide
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge mclk);
    regWrite = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge mclk);
    regWrite = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge mclk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge mclk);
    regRead = 1'b0;
    d = regRdData;
  endtask

  function automatic logic [23:0] fold(input logic [23:0] s, input logic [23:0] d);
    return (s << 1) ^ d ^ (s[23] ? `DCS_SIG_POLY : 24'h0);
  endfunction

  task automatic tRegs;
    logic [31:0] d;
    chk("inDiv at reset", 32'd2, 32'(pllInputDivisor));
    rd(8'h28, d);
    chk("sig reset", 32'h100, d);
    rd(8'h2c, d);
    chk("unmapped", 32'h0, d);
    wr(8'h24, 32'hffffffff);
    rd(8'h24, d);
    chk("dot reg", 32'hdffffd07, d);
    wr(8'h28, 32'hffffffee);
    rd(8'h28, d);
    chk("sig reg", 32'h000001ee, d);
    wr(8'h28, 32'h0);
  endtask

  task automatic tInDiv;
    for (int c = 0; c < 8; c++) begin
      wr(8'h24, 32'(c));
      repeat (2) @(negedge mclk);
      chk("inDiv", 32'(c + 2), 32'(pllInputDivisor));
    end
  endtask

  task automatic tPost(input logic [4:0] c, input logic [4:0] e);
    wr(8'h24, {3'b0, c, 24'h0});
    repeat (2) @(negedge mclk);
    chk("postDiv", 32'(e), 32'(postDivisor));
    chk("pllOn", 32'(c == 5'h0f), 32'(pllEnabled));
  endtask

  task automatic tFb(input logic p, input logic [10:0] c, input int e);
    int k;
    wr(8'h24, {8'h0, p, c, 12'h800});
    repeat (2) @(negedge mclk);
    for (k = 0; k < 1000 && feedbackValid !== 1'b1; k++) @(negedge mclk);
    guard(k, 1000);
    @(negedge mclk);
    chk("fbDiv", 32'(e), 32'(feedbackDivisor));
    chk("pllOn", 32'h1, 32'(pllEnabled));
  endtask

  // dot clock pulses over 200 cycles, i.e. twenty reference edges
  task automatic tDot(input logic [31:0] cfg, input int e);
    int n;
    n = 0;
    wr(8'h24, cfg);
    repeat (20) @(negedge mclk);
    chk("vcoDown", 32'(cfg[8]), 32'(vcoPowerDown));
    repeat (200) begin
      @(negedge mclk);
      n += (dotClock === 1'b1);
    end
    chk("dot rate", 32'h1, 32'(n >= e - 2 && n <= e + 2));
  endtask

  task automatic tPanel(input logic [3:0] l, input logic [7:0] c,
                        input logic [3:0] e);
    lvl = l;
    wr(8'h28, {24'h0, c});
    repeat (6) @(negedge mclk);
    chk("panel pins", 32'(e), {28'h0, panelVerticalSyncPin,
        panelHorizontalSyncPin, panelClock, panelEvenClock});
  endtask

  task automatic hLat(output int n);
    int k;
    n = 0;
    for (k = 0; k < 100 && pins.crtHsync !== 1'b1; k++) @(negedge mclk);
    guard(k, 100);
    for (; n < 20 && panelHorizontalSyncPin !== 1'b1; n++) @(negedge mclk);
    guard(n, 20);
  endtask

  task automatic tHdelay;
    int a, b;
    wr(8'h28, 32'h80);
    fork pm.frame(8); hLat(a); join
    wr(8'h28, 32'h82);
    fork pm.frame(8); hLat(b); join
    chk("hsync delay", 32'd2, 32'(b - a));
    wr(8'h28, 32'h0);
  endtask

  // two frames; without free-run only the first one is folded in
  task automatic tSig(input logic src, input logic fr);
    logic [23:0] e;
    logic [17:0] p;
    logic [31:0] d;
    e = 24'h000001;
    wr(8'h28, {28'h0, src, fr, 2'b01});
    pm.frame(8);
    pm.frame(8);
    for (int f = 0; f < (fr ? 2 : 1); f++)
      for (int i = 0; i < 8; i++) begin
        p = 18'h2a5c0 ^ 18'(i);
        e = fold(e, src ? {p[17:12], 2'b0, p[11:6], 2'b0, p[5:0], 2'b0}
                        : 24'h5a3c00 + 24'(i));
      end
    rd(8'h28, d);
    chk("signature", {8'h0, e}, {8'h0, d[31:8]});
    wr(8'h28, 32'h0);
    rd(8'h28, d);
    chk("sig cleared", 32'h100, d);
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h0;
    regWrData = 32'h0;
    lvl = 4'h0;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    tRegs();
    tInDiv();
    tPost(5'h00, 5'd8);
    tPost(5'h07, 5'd2);
    tPost(5'h0f, 5'd1);
    tPost(5'h1e, 5'd31);
    tPost(5'h1f, 5'd0);
    tFb(1'b0, 11'h3ff, 2);
    tFb(1'b1, 11'h33a, 801);
    tFb(1'b1, 11'h5ff, 5);
    // feedback 3 over input 2 by post 1: 1.5 ticks per reference edge
    tDot(32'h0fbff000, 30);
    tDot(32'h0f3ff100, 20);
    tPanel(4'b1010, 8'h00, 4'b1010);
    tPanel(4'b1010, 8'h60, 4'b1001);
    tPanel(4'b1111, 8'h80, 4'b0011);
    tHdelay();
    tSig(1'b0, 1'b0);
    tSig(1'b1, 1'b0);
    tSig(1'b0, 1'b1);
    results();
  end
endmodule
